// ---- hdl/nv_flash_controller.sv ----
// flash sequencer: APB register/indexed port, memory port, array port
// assumes the array answers reads within the programmed wait count
// and that the memory master holds MEM_REQ until MEM_DONE
//
// Contract
// - main array is 128 pages of 8 rows of 256 bytes, indexed
// - separate 512-byte information area of two rows
// - eight 32 KB blocks; writes to protected blocks refused
// - write-protect pin protects lowest block from programming
// - every array read waits the programmed wait-state count
// - memory port reaches main array only; info via data port
// - data port read returns byte at page, row, column index
// - every data port access advances the index by one
// - data port single byte write stalls until programming ends
// - memory write programs one byte, stalling until done
// - memory writes are always single-byte; row mode only via data port
// - row mode starts when row_program_enable is set
// - row mode keeps high voltage on until last column programmed
// - each row mode byte stalls the writer until programmed
// - row time-out aborts the row and sets the time-out flag
// - non-conflicting reads continue while a row is programmed
`timescale 1ns/1ps
`default_nettype none
module nv_flash_controller
  import flash_ctl_pkg::*;
#(
  parameter int SINGLE_CYC = SINGLE_PROG_CYC,
  parameter int ROW_CYC = ROW_BYTE_CYC,
  parameter int ROW_LIMIT = ROW_LIMIT_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WP_N,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [17:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA,
  output logic MEM_DONE,
  output logic ARR_RD,
  output logic [17:0] ARR_RADDR,
  output logic ARR_RINFO,
  input wire logic [7:0] ARR_RDATA,
  output logic ARR_PROG,
  output logic ARR_HV,
  output logic [17:0] ARR_PADDR,
  output logic ARR_PINFO,
  output logic [7:0] ARR_WDATA
);
  typedef struct packed {
    logic wp1;
    logic wp2;
    logic mem_en;
    logic [2:0] ws;
    logic info_en;
    logic [ADDR_W-1:0] idx;
    logic [7:0] prot;
    logic row_en;
    logic timeout;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic mem_done;
    logic [7:0] mem_rdata;
    src_t rd_src;
    logic [2:0] rd_cnt;
    logic arr_rd;
    logic [ADDR_W-1:0] raddr;
    logic rinfo;
    prog_t ps;
    src_t prog_src;
    logic prow;
    logic [BYTE_CNT_W-1:0] byte_cnt;
    logic [ROW_CNT_W-1:0] row_cnt;
    logic arr_prog;
    logic hv;
    logic [ADDR_W-1:0] paddr;
    logic pinfo;
    logic [7:0] pdata;
  } state_t;

  localparam state_t ST_RST = '{mem_en: CTRL_EN_RST, ws: CTRL_WS_RST,
    prot: PROT_RST, rd_src: SRC_NONE, ps: P_IDLE, prog_src: SRC_NONE,
    default: '0};

  state_t st;
  state_t next_st;

  function automatic logic [ADDR_W-1:0] index_step(
    input logic [ADDR_W-1:0] i);
    // one adder: column carries into row, row into page
    return i + 18'h1;
  endfunction

  function automatic logic [ADDR_W-1:0] index_addr(
    input logic [ADDR_W-1:0] i, input logic info);
    // info area: low row bit picks one of two 256-byte rows
    return info ? {9'h000, i[8], i[7:0]} : i;
  endfunction

  function automatic logic block_locked(
    input logic [ADDR_W-1:0] a, input logic info,
    input logic [7:0] prot, input logic wp);
    logic [2:0] blk;
    blk = a[ADDR_W-1:BLOCK_LSB];
    // info rows are outside the block scheme
    return !info && (prot[blk] || (wp && blk == 3'h0));
  endfunction

  logic wp_on;
  logic apb_acc;
  logic is_data;
  logic mem_acc;
  logic row_expire;
  logic mem_rd_go;
  logic mem_wr_go;
  logic conflict_mem;
  logic conflict_io;

  always_comb
  begin
    next_st = st;
    next_st.wp1 = WP_N;
    next_st.wp2 = st.wp1;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.mem_done = 1'b0;
    wp_on = !st.wp2;
    apb_acc = PSEL && PENABLE && !st.pready;
    is_data = PADDR == OFF_DATA;
    mem_acc = MEM_REQ && !st.mem_done;
    row_expire = st.prow && st.ps != P_IDLE &&
      st.row_cnt >= ROW_CNT_W'(ROW_LIMIT - 1);
    // reads of the row under programming must wait for it
    conflict_mem = st.ps != P_IDLE && !st.pinfo &&
      MEM_ADDR[17:8] == st.paddr[17:8];
    conflict_io = st.ps != P_IDLE && st.info_en == st.pinfo &&
      index_addr(st.idx, st.info_en) >> 8 == st.paddr >> 8;
    mem_rd_go = mem_acc && st.mem_en && !MEM_WE &&
      st.rd_src == SRC_NONE && !conflict_mem;
    mem_wr_go = mem_acc && st.mem_en && MEM_WE && st.ps == P_IDLE &&
      !block_locked(MEM_ADDR, 1'b0, st.prot, wp_on);

    // plain registers answer on the cycle after the access phase starts
    if (apb_acc && !is_data)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0;
      case (PADDR)
        OFF_CTRL:
        begin
          if (PWRITE)
          begin
            next_st.mem_en = PWDATA[CTRL_EN_BIT];
            next_st.ws = PWDATA[CTRL_WS_LSB +: 3];
          end
          next_st.prdata[CTRL_EN_BIT] = st.mem_en;
          next_st.prdata[CTRL_WS_LSB +: 3] = st.ws;
        end
        OFF_PAGE:
        begin
          if (PWRITE)
          begin
            next_st.idx[17:11] = PWDATA[6:0];
            next_st.info_en = PWDATA[PAGE_INFO_BIT];
          end
          next_st.prdata[7:0] = {st.info_en, st.idx[17:11]};
        end
        OFF_ROW:
        begin
          if (PWRITE)
            next_st.idx[10:8] = PWDATA[2:0];
          next_st.prdata[2:0] = st.idx[10:8];
        end
        OFF_COL:
        begin
          if (PWRITE)
            next_st.idx[7:0] = PWDATA[7:0];
          next_st.prdata[7:0] = st.idx[7:0];
        end
        OFF_PROT:
        begin
          if (PWRITE)
            next_st.prot = PWDATA[7:0];
          next_st.prdata[7:0] = st.prot;
        end
        OFF_PGCTL:
        begin
          if (PWRITE)
            next_st.row_en = PWDATA[PGCTL_ROW_BIT];
          next_st.prdata[PGCTL_ROW_BIT] = st.row_en;
        end
        OFF_STATUS:
        begin
          if (PWRITE && PWDATA[STAT_TMO_BIT])
            next_st.timeout = 1'b0;
          next_st.prdata[STAT_BUSY_BIT] = st.ps != P_IDLE;
          next_st.prdata[STAT_TMO_BIT] = st.timeout;
          next_st.prdata[STAT_ROW_BIT] = st.prow;
          next_st.prdata[STAT_WP_BIT] = wp_on;
        end
        default:
          next_st.pslverr = 1'b1;
      endcase
    end

    // read engine: array read strobe held for ws+1 cycles
    if (st.rd_src != SRC_NONE)
    begin
      if (st.rd_cnt == 3'h0)
      begin
        next_st.arr_rd = 1'b0;
        next_st.rd_src = SRC_NONE;
        if (st.rd_src == SRC_IO)
        begin
          next_st.pready = 1'b1;
          next_st.prdata = {24'h0, ARR_RDATA};
          next_st.idx = index_step(st.idx);
        end
        else
        begin
          next_st.mem_done = 1'b1;
          next_st.mem_rdata = ARR_RDATA;
        end
      end
      else
        next_st.rd_cnt = st.rd_cnt - 3'h1;
    end
    else if (mem_rd_go)
    begin
      next_st.rd_src = SRC_MEM;
      next_st.rd_cnt = st.ws;
      next_st.arr_rd = 1'b1;
      next_st.raddr = MEM_ADDR;
      next_st.rinfo = 1'b0;
    end
    else if (apb_acc && is_data && !PWRITE && !conflict_io)
    begin
      next_st.rd_src = SRC_IO;
      next_st.rd_cnt = st.ws;
      next_st.arr_rd = 1'b1;
      next_st.raddr = index_addr(st.idx, st.info_en);
      next_st.rinfo = st.info_en;
    end

    // memory port: disabled space answers at once, data reads zero
    if (mem_acc && !st.mem_en)
    begin
      next_st.mem_done = 1'b1;
      next_st.mem_rdata = 8'h00;
    end
    else if (mem_acc && MEM_WE &&
      block_locked(MEM_ADDR, 1'b0, st.prot, wp_on))
      next_st.mem_done = 1'b1;

    // program engine
    if (st.ps == P_BYTE && st.byte_cnt != '0)
      next_st.byte_cnt = st.byte_cnt - BYTE_CNT_W'(1);
    if (st.prow && st.ps != P_IDLE)
      next_st.row_cnt = st.row_cnt + ROW_CNT_W'(1);
    if (row_expire)
    begin
      // abort the row; a byte in flight still releases its writer
      next_st.ps = P_IDLE;
      next_st.hv = 1'b0;
      next_st.arr_prog = 1'b0;
      next_st.prow = 1'b0;
      next_st.row_en = 1'b0;
      next_st.timeout = 1'b1;
      if (st.ps == P_BYTE)
      begin
        next_st.pready = 1'b1;
        next_st.prdata = 32'h0;
        next_st.idx = index_step(st.idx);
      end
    end
    else if (st.ps == P_BYTE && st.byte_cnt == '0)
    begin
      next_st.arr_prog = 1'b0;
      if (st.prog_src == SRC_IO)
      begin
        next_st.pready = 1'b1;
        next_st.prdata = 32'h0;
        next_st.idx = index_step(st.idx);
      end
      else
        next_st.mem_done = 1'b1;
      if (st.prow && st.paddr[7:0] != LAST_COL)
        next_st.ps = P_ROWWAIT;
      else
      begin
        next_st.ps = P_IDLE;
        next_st.hv = 1'b0;
        next_st.prow = 1'b0;
        if (st.prow)
          next_st.row_en = 1'b0;
      end
    end
    else if (st.ps == P_ROWWAIT && !st.row_en)
    begin
      // software dropped row mode mid-row
      next_st.ps = P_IDLE;
      next_st.hv = 1'b0;
      next_st.prow = 1'b0;
    end

    // starting a byte: memory writer first, always single-byte
    if (!row_expire && mem_wr_go)
    begin
      next_st.ps = P_BYTE;
      next_st.prog_src = SRC_MEM;
      next_st.prow = 1'b0;
      next_st.byte_cnt = BYTE_CNT_W'(SINGLE_CYC - 1);
      next_st.arr_prog = 1'b1;
      next_st.hv = 1'b1;
      next_st.paddr = MEM_ADDR;
      next_st.pinfo = 1'b0;
      next_st.pdata = MEM_WDATA;
    end
    else if (apb_acc && is_data && PWRITE)
    begin
      if (block_locked(st.idx, st.info_en, st.prot, wp_on))
      begin
        next_st.pready = 1'b1;
        next_st.prdata = 32'h0;
        next_st.idx = index_step(st.idx);
      end
      else if (!row_expire && (st.ps == P_IDLE ||
        (st.ps == P_ROWWAIT && st.row_en)))
      begin
        next_st.ps = P_BYTE;
        next_st.prog_src = SRC_IO;
        next_st.prow = st.row_en;
        if (st.ps == P_IDLE)
          next_st.row_cnt = '0;
        next_st.byte_cnt = st.row_en ? BYTE_CNT_W'(ROW_CYC - 1) :
          BYTE_CNT_W'(SINGLE_CYC - 1);
        next_st.arr_prog = 1'b1;
        next_st.hv = 1'b1;
        next_st.paddr = index_addr(st.idx, st.info_en);
        next_st.pinfo = st.info_en;
        next_st.pdata = PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      st <= ST_RST;
    else if (CE)
      st <= next_st;
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign MEM_RDATA = st.mem_rdata;
  assign MEM_DONE = st.mem_done;
  assign ARR_RD = st.arr_rd;
  assign ARR_RADDR = st.raddr;
  assign ARR_RINFO = st.rinfo;
  assign ARR_PROG = st.arr_prog;
  assign ARR_HV = st.hv;
  assign ARR_PADDR = st.paddr;
  assign ARR_PINFO = st.pinfo;
  assign ARR_WDATA = st.pdata;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_byte_start;
    CE && st.ps != P_BYTE && next_st.ps == P_BYTE;
  endsequence

  sequence s_data_done;
    CE && PSEL && PENABLE && PREADY && PADDR == OFF_DATA;
  endsequence

  a_boot_lock: assert property (s_byte_start |->
    !(wp_on && !next_st.pinfo && next_st.paddr[17:15] == 3'h0))
    else $error("boot block programmed while write-protect asserted");
  a_block_lock: assert property (s_byte_start |->
    !(!next_st.pinfo && st.prot[next_st.paddr[17:15]]))
    else $error("protected block programmed");
  a_single_stall: assert property (st.ps == P_BYTE &&
    st.prog_src == SRC_IO && st.byte_cnt != '0 |-> !PREADY)
    else $error("data port released before byte programmed");
  a_row_hv_hold: assert property (st.ps == P_ROWWAIT |-> ARR_HV &&
    !ARR_PROG)
    else $error("high voltage dropped between row bytes");
  a_index_step: assert property (s_data_done |->
    st.idx == $past(st.idx) + 18'h1)
    else $error("index did not advance after data access");
  a_read_wait: assert property (CE && $rose(ARR_RD) |->
    st.rd_cnt == st.ws)
    else $error("array read shorter than wait setting");
  // a zero wait count still gives one strobe cycle, so hold only while counting
  a_read_hold: assert property (CE && ARR_RD && st.rd_cnt != 3'h0 |=>
    ARR_RD)
    else $error("array read strobe dropped before wait count ran out");
  a_mem_no_info: assert property (st.rd_src == SRC_MEM |->
    !ARR_RINFO)
    else $error("memory port reached information area");
  a_mem_single: assert property (st.prog_src == SRC_MEM &&
    st.ps != P_IDLE |-> !st.prow)
    else $error("memory write used row mode");
  a_tmo_abort: assert property (CE && row_expire |=>
    st.timeout && !ARR_HV && st.ps == P_IDLE)
    else $error("row time-out did not abort");
  a_mem_stall: assert property (CE && st.ps == P_BYTE &&
    st.prog_src == SRC_MEM && st.byte_cnt == '0 && !row_expire |=>
    MEM_DONE && !ARR_PROG)
    else $error("memory write not released at byte end");
  a_lock_fast: assert property (CE && mem_acc && MEM_WE && st.mem_en &&
    block_locked(MEM_ADDR, 1'b0, st.prot, wp_on) |=>
    MEM_DONE && !($rose(ARR_PROG) && st.prog_src == SRC_MEM))
    else $error("protected memory write stalled or programmed");
endmodule
`default_nettype wire

// ---- inc/flash_ctl_pkg.sv ----
// shared constants of the on-chip flash program/read controller
// assumes a 250 MHz REF_CLK and an APB register bus with 32-bit words
package flash_ctl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PAGE = 8'h04;
  localparam logic [7:0] OFF_ROW = 8'h08;
  localparam logic [7:0] OFF_COL = 8'h0c;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [7:0] OFF_PROT = 8'h14;
  localparam logic [7:0] OFF_PGCTL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WS_LSB = 1;
  localparam int PAGE_INFO_BIT = 7;
  localparam int PGCTL_ROW_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TMO_BIT = 1;
  localparam int STAT_ROW_BIT = 2;
  localparam int STAT_WP_BIT = 3;
  // array geometry: 128 pages x 8 rows x 256 bytes
  localparam int PAGES = 128;
  localparam int ROW_BYTES = 256;
  localparam int ADDR_W = 18;
  localparam int BLOCK_LSB = 15;
  localparam logic [7:0] LAST_COL = 8'hff;
  // reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [2:0] CTRL_WS_RST = 3'h4;
  localparam logic [7:0] PROT_RST = 8'h00;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int SINGLE_PROG_US = 66;
  localparam int ROW_BYTE_US = 41;
  localparam int ROW_LIMIT_MS = 31;
  localparam int SINGLE_PROG_CYC = SINGLE_PROG_US * CLK_MHZ;
  localparam int ROW_BYTE_CYC = ROW_BYTE_US * CLK_MHZ;
  localparam int ROW_LIMIT_CYC = ROW_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int BYTE_CNT_W = 16;
  localparam int ROW_CNT_W = 23;
  // program engine states and request sources
  typedef enum logic [1:0]
  {
    P_IDLE = 2'b00,
    P_BYTE = 2'b01,
    P_ROWWAIT = 2'b10
  } prog_t;
  typedef enum logic [1:0]
  {
    SRC_NONE = 2'b00,
    SRC_IO = 2'b01,
    SRC_MEM = 2'b10
  } src_t;
endpackage

// ---- bench/flash_array_model.sv ----
// behavioural flash array: main area plus a separate info area
// assumes registered read and program strobes from the controller
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
(
  input wire logic clk,
  input wire logic rd,
  input wire logic [17:0] raddr,
  input wire logic rinfo,
  output logic [7:0] rdata,
  input wire logic prog,
  input wire logic [17:0] paddr,
  input wire logic pinfo,
  input wire logic [7:0] wdata,
  output int progs
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  logic prog_q = 1'b0;
  initial progs = 0;
  // info bit in the key keeps the two areas apart
  function automatic logic [7:0] get(input int k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction
  // idle read bus shows the inverse so a stale sample is caught
  assign rdata = rd ? get(int'({rinfo, raddr})) : ~last;
  always @(posedge clk)
  begin
    if (rd)
      last <= rdata;
    prog_q <= prog;
    // programming only clears bits, as real cells do
    if (prog && !prog_q)
    begin
      mem[int'({pinfo, paddr})] = get(int'({pinfo, paddr})) & wdata;
      progs <= progs + 1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench of the flash controller, fixed-seed random
// assumes the array model on the far side and one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("[ERR] %0t got %h want %h", $time, a, b); \
    end \
  end
module tb
  import flash_ctl_pkg::*;
;
  localparam int SC = 20;
  localparam int RC = 10;
  localparam int RL = 400;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ev, wp_n = 1'b1, mreq = 1'b0, mwe = 1'b0;
  logic [17:0] maddr = 18'h0, araddr, apaddr, a;
  logic [7:0] mwd = 8'h00, mrd, arrd, awd, d, c;
  logic mdone, ard, arinfo, aprog, ahv, apinfo;
  logic ce = 1'b1;
  logic [6:0] p;
  logic [2:0] r;
  int progs, lat, l0, n, cyc = 0, miscompares = 0, n_tests = 0;
  logic [7:0] sh [int];
  always #2 clk = ~clk;
  nv_flash_controller #(.SINGLE_CYC(SC), .ROW_CYC(RC), .ROW_LIMIT(RL)) dut
  (
    .REF_CLK(clk), .RESET(rst), .CE(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WP_N(wp_n), .MEM_REQ(mreq),
    .MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RDATA(mrd),
    .MEM_DONE(mdone), .ARR_RD(ard), .ARR_RADDR(araddr),
    .ARR_RINFO(arinfo), .ARR_RDATA(arrd), .ARR_PROG(aprog),
    .ARR_HV(ahv), .ARR_PADDR(apaddr), .ARR_PINFO(apinfo),
    .ARR_WDATA(awd)
  );
  flash_array_model arr
  (
    .clk(clk), .rd(ard), .raddr(araddr), .rinfo(arinfo), .rdata(arrd),
    .prog(aprog), .paddr(apaddr), .pinfo(apinfo), .wdata(awd),
    .progs(progs)
  );
  function automatic logic [17:0] at(input logic [6:0] pg,
    input logic [2:0] rw, input logic [7:0] cl);
    return {pg, rw, cl};
  endfunction
  function automatic logic [7:0] ex(input int k);
    return sh.exists(k) ? sh[k] : 8'hff;
  endfunction
  task automatic put(input int k, input logic [7:0] v);
    sh[k] = ex(k) & v;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    lat = 0;
    do
    begin
      @(posedge clk);
      lat++;
    end
    while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic idx(input logic [6:0] pg, input logic [2:0] rw,
    input logic [7:0] cl);
    wr(OFF_PAGE, {25'h0, pg});
    wr(OFF_ROW, {29'h0, rw});
    wr(OFF_COL, {24'h0, cl});
  endtask
  task automatic mem(input logic w, input logic [17:0] ad,
    input logic [7:0] wd);
    @(posedge clk);
    mreq <= 1'b1;
    mwe <= w;
    maddr <= ad;
    mwd <= wd;
    lat = 0;
    do
    begin
      @(posedge clk);
      lat++;
    end
    while (mdone !== 1'b1);
    rv = {24'h0, mrd};
    mreq <= 1'b0;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test;
    end
  end
  initial
  begin
    void'($urandom(11));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL);
    `CHK(rv, 32'h9)
    rd(OFF_PROT);
    `CHK(rv, 32'h0)
    rd(8'h24);
    `CHK(ev, 1'b1)
    $display("test reset done");
    repeat (4)
    begin
      p = 7'($urandom_range(127, 16));
      r = 3'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      n = progs;
      idx(p, r, c);
      wr(OFF_DATA, {24'h0, d});
      `CHK(lat > SC, 1'b1)
      `CHK(progs, n + 1)
      put(at(p, r, c), d);
      rd(OFF_COL);
      `CHK(rv[7:0], c + 8'h01)
      idx(p, r, c);
      rd(OFF_DATA);
      `CHK(rv[7:0], ex(at(p, r, c)))
      mem(1'b0, at(p, r, c), 8'h00);
      `CHK(rv[7:0], ex(at(p, r, c)))
    end
    $display("test single done");
    // read another row through memory while this byte programs
    idx(p, r ^ 3'h1, 8'h00);
    fork
      wr(OFF_DATA, 32'h0);
      begin
        repeat (4) @(posedge clk);
        mem(1'b0, at(p, r, c), 8'h00);
        `CHK(rv[7:0], ex(at(p, r, c)))
        `CHK(aprog, 1'b1)
      end
    join
    put(at(p, r ^ 3'h1, 8'h00), 8'h00);
    $display("test overlap done");
    p = 7'($urandom_range(126, 16));
    idx(p, 3'h7, 8'hff);
    rd(OFF_DATA);
    rd(OFF_PAGE);
    `CHK(rv[6:0], p + 7'h1)
    rd(OFF_ROW);
    `CHK(rv[2:0], 3'h0)
    rd(OFF_COL);
    `CHK(rv[7:0], 8'h00)
    $display("test wrap done");
    for (int b = 0; b < 8; b++)
    begin
      wr(OFF_PROT, 32'h1 << b);
      n = progs;
      idx({3'(b), 4'h2}, 3'h3, 8'h11);
      wr(OFF_DATA, 32'h0);
      `CHK(lat < 4, 1'b1)
      mem(1'b1, at({3'(b), 4'h2}, 3'h3, 8'h12), 8'h00);
      `CHK(progs, n)
    end
    wr(OFF_PROT, 32'h0);
    $display("test protect done");
    wp_n <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFF_STATUS);
    `CHK(rv[STAT_WP_BIT], 1'b1)
    n = progs;
    a = at(7'h05, 3'h1, 8'h40);
    mem(1'b1, a, 8'h5a);
    `CHK(progs, n)
    wp_n <= 1'b1;
    repeat (3) @(posedge clk);
    mem(1'b1, a, 8'h5a);
    `CHK(lat > SC, 1'b1)
    put(a, 8'h5a);
    mem(1'b0, a, 8'h00);
    `CHK(rv[7:0], ex(a))
    `CHK(progs, n + 1)
    $display("test boot block done");
    c = 8'($urandom_range(254, 0));
    wr(OFF_PAGE, 32'h80);
    wr(OFF_ROW, 32'h1);
    wr(OFF_COL, {24'h0, c});
    wr(OFF_DATA, 32'h3c);
    put(int'({1'b1, 9'h0, 1'b1, c}), 8'h3c);
    wr(OFF_COL, {24'h0, c});
    rd(OFF_DATA);
    `CHK(rv[7:0], ex(int'({1'b1, 9'h0, 1'b1, c})))
    mem(1'b0, {9'h0, 1'b1, c}, 8'h00);
    `CHK(rv[7:0], ex(int'({9'h0, 1'b1, c})))
    $display("test info done");
    // ws 0 against ws 7 on the same read path
    wr(OFF_CTRL, 32'h1);
    rd(OFF_DATA);
    l0 = lat;
    wr(OFF_CTRL, 32'hf);
    rd(OFF_DATA);
    `CHK(lat - l0, 7)
    // freeze five cycles mid-read: the answer slips by exactly five
    fork
      rd(OFF_DATA);
      begin
        repeat (4) @(posedge clk);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
      end
    join
    `CHK(lat - l0, 12)
    wr(OFF_CTRL, 32'h9);
    $display("test wait done");
    p = 7'($urandom_range(127, 16));
    r = 3'($urandom);
    d = 8'($urandom);
    idx(p, r, 8'hfe);
    wr(OFF_PGCTL, 32'h1);
    wr(OFF_DATA, {24'h0, d});
    `CHK(lat > RC && lat < SC, 1'b1)
    `CHK(ahv, 1'b1)
    wr(OFF_DATA, {24'h0, ~d});
    `CHK(ahv, 1'b0)
    rd(OFF_PGCTL);
    `CHK(rv[PGCTL_ROW_BIT], 1'b0)
    put(at(p, r, 8'hfe), d);
    put(at(p, r, 8'hff), ~d);
    idx(p, r, 8'hfe);
    rd(OFF_DATA);
    `CHK(rv[7:0], ex(at(p, r, 8'hfe)))
    rd(OFF_DATA);
    `CHK(rv[7:0], ex(at(p, r, 8'hff)))
    $display("test row done");
    // stop writing the row once its time-out is seen
    p = p ^ 7'h01;
    idx(p, r, 8'h00);
    wr(OFF_PGCTL, 32'h1);
    n = 0;
    do
    begin
      wr(OFF_DATA, {24'h0, 8'($urandom)});
      rd(OFF_STATUS);
      n++;
    end
    while (rv[STAT_TMO_BIT] !== 1'b1 && n < 100);
    `CHK(n > RL / 30 && n <= RL / RC, 1'b1)
    `CHK(ahv, 1'b0)
    wr(OFF_STATUS, 32'h2);
    rd(OFF_STATUS);
    `CHK(rv[STAT_TMO_BIT], 1'b0)
    $display("test timeout done");
    finish_test;
  end
endmodule
`default_nettype wire
